// file: src/rcw_radio_ctrl.sv
// serial control word register, synthesizer decode and dc extractor
module rcw_radio_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_en_n,
    input wire logic offset_phase_ctrl,
    input wire logic [7:0] rx_sample,
    output logic [11:0] main_div_ratio,
    output logic [4:0] ref_div_ratio,
    output logic [1:0] tx_level,
    output logic rx_mode,
    output logic tx_mode,
    output logic pll_hold,
    output logic pll_on,
    output logic word_loaded,
    output logic [31:0] ctrl_word,
    output rcw_pkg::rcw_phase_t dc_phase,
    output logic [7:0] slicer_ref,
    output logic rx_data
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] ref_ratio(input logic [1:0] sel);
        logic [4:0] r;
        unique case (sel)
            2'b00: r = rcw_pkg::REF_DIV_00;
            2'b01: r = rcw_pkg::REF_DIV_01;
            2'b10: r = rcw_pkg::REF_DIV_10;
            2'b11: r = rcw_pkg::REF_DIV_11;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] mid(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8:1];
    endfunction

    // first-order step toward the sample; shift sets the tracking speed
    function automatic logic [7:0] step(input logic [7:0] est, input logic [7:0] s,
                                        input int sh);
        logic signed [9:0] d;
        logic signed [9:0] r;
        d = signed'({2'b00, s}) - signed'({2'b00, est});
        r = signed'({2'b00, est}) + (d >>> sh);
        return r[7:0];
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    rcw_pkg::rcw_link_t link_s1;
    rcw_pkg::rcw_link_t link_s2;
    rcw_pkg::rcw_link_t link_s3;
    logic tl_s1;
    logic tl_s2;
    logic tl_s3;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            link_s1 <= rcw_pkg::LINK_RST;
            link_s2 <= rcw_pkg::LINK_RST;
            link_s3 <= rcw_pkg::LINK_RST;
            tl_s1 <= 1'b0;
            tl_s2 <= 1'b0;
            tl_s3 <= 1'b0;
        end
        else
        begin
            link_s1 <= '{clk: ser_clk, data: ser_data, en_n: ser_en_n};
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            tl_s1 <= offset_phase_ctrl;
            tl_s2 <= tl_s1;
            tl_s3 <= tl_s2;
        end
    end

    logic sclk_rise;
    logic en_rise;
    logic tl_rise;
    logic tl_fall;
    assign sclk_rise = link_s2.clk & ~link_s3.clk;
    assign en_rise = link_s2.en_n & ~link_s3.en_n;
    assign tl_rise = tl_s2 & ~tl_s3;
    assign tl_fall = ~tl_s2 & tl_s3;

    // ------------------------------------------------------------
    // serial shift register and control word
    // ------------------------------------------------------------
    logic [31:0] shift_reg;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            shift_reg <= 32'h0000_0000;
        else if (sclk_rise && !link_s2.en_n)
            shift_reg <= {shift_reg[30:0], link_s2.data};
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_word <= rcw_pkg::CTRL_RST;
            word_loaded <= 1'b0;
        end
        else
        begin
            word_loaded <= en_rise;
            if (en_rise)
                ctrl_word <= shift_reg;
        end
    end

    load_word_a: assert property (@(posedge sys_clk) disable iff (rst)
        en_rise |=> (ctrl_word == $past(shift_reg)) && word_loaded)
        else $error("control word not loaded on enable rise");

    shift_msb_a: assert property (@(posedge sys_clk) disable iff (rst)
        (sclk_rise && !link_s2.en_n) |=>
            shift_reg == {$past(shift_reg[30:0]), $past(link_s2.data)})
        else $error("serial bit not shifted in at lsb");

    no_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
        link_s2.en_n |=> $stable(shift_reg))
        else $error("shift register moved while enable high");

    // ------------------------------------------------------------
    // synthesizer and mode decode
    // ------------------------------------------------------------
    rcw_pkg::rcw_cfg_t cfg;
    assign cfg = ctrl_word[rcw_pkg::CFG_W-1:0];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            main_div_ratio <= rcw_pkg::MAIN_BASE;
            ref_div_ratio <= ref_ratio(rcw_pkg::CTRL_RST[rcw_pkg::REF_HI:rcw_pkg::REF_LO]);
            tx_level <= 2'h0;
            rx_mode <= 1'b0;
            tx_mode <= 1'b1;
            pll_hold <= 1'b0;
        end
        else
        begin
            main_div_ratio <= rcw_pkg::MAIN_BASE + {4'h0, cfg.chan};
            ref_div_ratio <= ref_ratio(cfg.refdiv_sel);
            tx_level <= cfg.tx_level;
            rx_mode <= cfg.rx_sel;
            tx_mode <= ~cfg.rx_sel;
            pll_hold <= cfg.pll_hold;
        end
    end

    // loop closes on each load, opens at demodulation start in rx mode unless held
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pll_on <= 1'b1;
        else if (word_loaded)
            pll_on <= 1'b1;
        else if (tl_rise && rx_mode && !pll_hold)
            pll_on <= 1'b0;
    end

    main_div_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 main_div_ratio == rcw_pkg::MAIN_BASE + {4'h0, $past(ctrl_word[7:0])})
        else $error("main divider not base plus channel");

    ref_div_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 ref_div_ratio == ref_ratio($past(ctrl_word[13:12])))
        else $error("reference divider decode wrong");

    mode_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (rx_mode == $past(ctrl_word[8])) && (tx_mode == !rx_mode))
        else $error("rx or tx mode does not follow bit 8");

    tx_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 tx_level == $past(ctrl_word[11:10]))
        else $error("power level does not follow bits 11..10");

    pll_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (pll_on && pll_hold) |=> pll_on)
        else $error("loop opened while hold bit set");

    // ------------------------------------------------------------
    // dc extractor
    // ------------------------------------------------------------
    logic [7:0] bit_cnt;
    logic bit_tick;
    logic [7:0] min_v;
    logic [7:0] max_v;

    always_ff @(posedge sys_clk)
    begin
        if (rst || bit_tick)
            bit_cnt <= 8'h00;
        else
            bit_cnt <= bit_cnt + 8'h01;
    end
    assign bit_tick = (bit_cnt == rcw_pkg::BIT_LAST);

    always_ff @(posedge sys_clk)
    begin
        if (rst || word_loaded)
            dc_phase <= rcw_pkg::PH_COARSE;
        else
        begin
            unique case (dc_phase)
                rcw_pkg::PH_COARSE:
                    if (tl_rise)
                        dc_phase <= rcw_pkg::PH_FINE;
                rcw_pkg::PH_FINE:
                    if (tl_fall)
                        dc_phase <= rcw_pkg::PH_HOLD;
                rcw_pkg::PH_HOLD:
                    if (tl_rise)
                        dc_phase <= rcw_pkg::PH_FINE;
                default:
                    dc_phase <= rcw_pkg::PH_COARSE;
            endcase
        end
    end

    // fast min/max tracker for the coarse phase
    always_ff @(posedge sys_clk)
    begin
        if (rst || word_loaded)
        begin
            min_v <= 8'hFF;
            max_v <= 8'h00;
        end
        else if (dc_phase == rcw_pkg::PH_COARSE)
        begin
            if (rx_sample < min_v)
                min_v <= rx_sample;
            if (rx_sample > max_v)
                max_v <= rx_sample;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            slicer_ref <= rcw_pkg::EST_RST;
        else
        begin
            unique case (dc_phase)
                rcw_pkg::PH_COARSE:
                    if (min_v <= max_v)
                        slicer_ref <= mid(min_v, max_v);
                rcw_pkg::PH_FINE:
                    if (bit_tick)
                        slicer_ref <= step(slicer_ref, rx_sample, rcw_pkg::FINE_SHIFT);
                rcw_pkg::PH_HOLD:
                    if (bit_tick)
                        slicer_ref <= step(slicer_ref, rx_sample, rcw_pkg::HOLD_SHIFT);
                default:
                    slicer_ref <= slicer_ref;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rx_data <= 1'b0;
        else
            rx_data <= (rx_sample >= slicer_ref);
    end

    fine_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        (dc_phase == rcw_pkg::PH_COARSE && tl_rise && !word_loaded && min_v <= max_v)
        |=> (dc_phase == rcw_pkg::PH_FINE) && (slicer_ref == mid($past(min_v), $past(max_v))))
        else $error("min/max estimate not loaded on timing rise");

    hold_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
        (dc_phase == rcw_pkg::PH_FINE && tl_fall && !word_loaded)
        |=> dc_phase == rcw_pkg::PH_HOLD)
        else $error("hold phase not entered on timing fall");

    hold_slow_a: assert property (@(posedge sys_clk) disable iff (rst)
        (dc_phase == rcw_pkg::PH_HOLD && !bit_tick) |=> $stable(slicer_ref))
        else $error("held estimate moved between bit ticks");

    slicer_out_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 rx_data == ($past(rx_sample) >= $past(slicer_ref)))
        else $error("slicer output wrong");

endmodule

// file: common/rcw_pkg.sv
// constants and types of the radio control word and dc extractor
package rcw_pkg;

    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int CFG_W = 14;
    localparam int CHAN_W = 8;
    localparam int REF_HI = 13;
    localparam int REF_LO = 12;
    localparam logic [31:0] CTRL_RST = 32'h0546_0000;
    localparam logic [11:0] MAIN_BASE = 12'h900;

    // reference divider ratios per select code
    localparam logic [4:0] REF_DIV_00 = 5'h0C;
    localparam logic [4:0] REF_DIV_01 = 5'h10;
    localparam logic [4:0] REF_DIV_10 = 5'h0D;
    localparam logic [4:0] REF_DIV_11 = 5'h1A;

    // ------------------------------------------------------------
    // extractor timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int BIT_TIME_NS = 1000;
    localparam int BIT_CYC = (BIT_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] BIT_LAST = 8'(BIT_CYC - 1);
    localparam int FINE_SHIFT = 2;
    localparam int HOLD_SHIFT = 6;
    localparam logic [7:0] EST_RST = 8'h80;

    typedef enum logic [1:0] {
        PH_COARSE = 2'b00,
        PH_FINE = 2'b01,
        PH_HOLD = 2'b10
    } rcw_phase_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic en_n;
    } rcw_link_t;

    typedef struct packed {
        logic [1:0] refdiv_sel;
        logic [1:0] tx_level;
        logic pll_hold;
        logic rx_sel;
        logic [7:0] chan;
    } rcw_cfg_t;

    localparam rcw_link_t LINK_RST = '{clk: 1'b0, data: 1'b0, en_n: 1'b1};

endpackage

// file: dv/rcw_bb_model.sv
// baseband controller model driving the serial bus and the extractor timing line
module rcw_bb_model (
    output logic ser_clk,
    output logic ser_data,
    output logic ser_en_n,
    output logic offset_phase_ctrl
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // idle levels: pins rest at their pull-down level, enable high
    // ------------------------------------------------------------
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_en_n = 1'b1;
        offset_phase_ctrl = 1'b0;
    end

    // ------------------------------------------------------------
    // one burst: extra leading bits, then the word msb first
    // ------------------------------------------------------------
    task automatic burst(input logic [31:0] word, input logic [3:0] lead);
        logic [35:0] bits;
        int n;
        bits = {lead, word};
        n = 32 + ((lead != 4'h0) ? 4 : 0);
        #7 ser_en_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            ser_data = bits[i];
            #24 ser_clk = 1'b1;
            #24 ser_clk = 1'b0;
        end
        #24 ser_en_n = 1'b1;
        ser_data = 1'b0;
    endtask

    // extractor timing line level, raised early and dropped at trailer end
    task automatic timing(input logic level);
        offset_phase_ctrl = level;
    endtask
endmodule

// file: dv/test_rcw_radio_ctrl.sv
// self-checking bench for the radio control word and dc extractor
module test_rcw_radio_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, rst, ser_clk, ser_data, ser_en_n, offset_phase_ctrl, swing;
    logic [7:0] rx_sample, s_prev, r_prev, slicer_ref, held_ref;
    logic [2:0] ph_cnt;
    logic [11:0] main_div_ratio;
    logic [4:0] ref_div_ratio;
    logic [1:0] tx_level;
    logic rx_mode, tx_mode, pll_hold, pll_on, word_loaded, rx_data, live;
    logic [31:0] ctrl_word, w;
    rcw_pkg::rcw_phase_t dc_phase;
    int bad_count = 0;
    int n_tests = 0;

    rcw_bb_model u_rcw_bb_model (.ser_clk(ser_clk), .ser_data(ser_data),
        .ser_en_n(ser_en_n), .offset_phase_ctrl(offset_phase_ctrl));

    rcw_radio_ctrl u_rcw_radio_ctrl (.sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_en_n(ser_en_n), .offset_phase_ctrl(offset_phase_ctrl),
        .rx_sample(rx_sample), .main_div_ratio(main_div_ratio),
        .ref_div_ratio(ref_div_ratio), .tx_level(tx_level), .rx_mode(rx_mode),
        .tx_mode(tx_mode), .pll_hold(pll_hold), .pll_on(pll_on),
        .word_loaded(word_loaded), .ctrl_word(ctrl_word), .dc_phase(dc_phase),
        .slicer_ref(slicer_ref), .rx_data(rx_data));

    // ------------------------------------------------------------
    // clock, samples and helpers
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // swinging demodulated signal around mid scale
    // half period of 8 cycles so that successive bit ticks see opposite levels
    always @(posedge sys_clk)
    begin
        ph_cnt <= ph_cnt + 3'h1;
        if (ph_cnt == 3'h7)
            swing <= ~swing;
        rx_sample <= swing ? 8'h40 : 8'hC0;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // slicer output one cycle behind its comparison
    always @(posedge sys_clk)
    begin
        #1;
        if (live === 1'b1)
            chk("rx_data", {31'h0, s_prev >= r_prev}, {31'h0, rx_data});
        s_prev = rx_sample;
        r_prev = slicer_ref;
    end

    function automatic logic [4:0] exp_ref(input logic [1:0] sel);
        case (sel)
            2'b00: return rcw_pkg::REF_DIV_00;
            2'b01: return rcw_pkg::REF_DIV_01;
            2'b10: return rcw_pkg::REF_DIV_10;
            default: return rcw_pkg::REF_DIV_11;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #200us;
        bad_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        swing = 1'b0;
        ph_cnt = 3'h0;
        held_ref = 8'h00;
        rx_sample = 8'h80;
        live = 1'b0;
        s_prev = 8'h00;
        r_prev = 8'h80;
        void'($urandom(99));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(2);
        chk("ctrl_word", rcw_pkg::CTRL_RST, ctrl_word);
        chk("main_div", {20'h0, rcw_pkg::MAIN_BASE}, {20'h0, main_div_ratio});
        chk("ref_div", {27'h0, rcw_pkg::REF_DIV_00}, {27'h0, ref_div_ratio});
        chk("phase", 32'h0, {30'h0, dc_phase});
        live = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            w = {5'h00, 4'($urandom), 7'h46, 2'b00, 2'(i), 2'(i >> 1),
                1'($urandom), 1'(i >> 2), 8'($urandom)};
            if (i == 9)
                w[7:0] = 8'hFF;
            if (i == 4)
                w[9] = 1'b0;
            if (i == 5)
                w[9] = 1'b1;
            if (w[8])
                w[7:0] = w[7:0] + 8'h01;
            u_rcw_bb_model.burst(w, (i % 3 == 0) ? 4'($urandom) | 4'h1 : 4'h0);
            for (int t = 0; t < 40 && word_loaded !== 1'b1; t++)
                cyc(1);
            chk("loaded", 32'h1, {31'h0, word_loaded});
            chk("ctrl_word", w, ctrl_word);
            cyc(2);
            chk("main_div", {20'h0, rcw_pkg::MAIN_BASE} + w[7:0], {20'h0, main_div_ratio});
            chk("ref_div", {27'h0, exp_ref(w[13:12])}, {27'h0, ref_div_ratio});
            chk("tx_level", {30'h0, w[11:10]}, {30'h0, tx_level});
            chk("rx_mode", {31'h0, w[8]}, {31'h0, rx_mode});
            chk("tx_mode", {31'h0, !w[8]}, {31'h0, tx_mode});
            chk("pll_hold", {31'h0, w[9]}, {31'h0, pll_hold});
            chk("phase", 32'h0, {30'h0, dc_phase});
            cyc(30);
            chk("slicer", 32'h80, {24'h0, slicer_ref});
            u_rcw_bb_model.timing(1'b1);
            cyc(8);
            chk("phase", 32'h1, {30'h0, dc_phase});
            chk("pll_on", {31'h0, !(w[8] && !w[9])}, {31'h0, pll_on});
            cyc(450);
            chk("ref_near", 32'h1, {31'h0, slicer_ref >= 8'h70 && slicer_ref <= 8'h90});
            u_rcw_bb_model.timing(1'b0);
            cyc(8);
            chk("phase", 32'h2, {30'h0, dc_phase});
            held_ref = slicer_ref;
            cyc(250);
            chk("hold_drift", 32'h1, {31'h0, slicer_ref - held_ref + 8'h04 <= 8'h08});
        end
        close_out();
    end
endmodule
